/* pna_cfg.svh */
`ifndef PNA_CFG_SVH
`define PNA_CFG_SVH

// Bus command codes carried on the command lanes in the address phase
`define PNA_CMD_MEM_RD 4'h6
`define PNA_CMD_MEM_WR 4'h7
`define PNA_CMD_CFG_RD 4'hA
`define PNA_CMD_CFG_WR 4'hB

// Memory window claimed as a target
`define PNA_MEM_BASE 32'hF000_0000
`define PNA_MEM_MASK 32'hFFFF_F000

// Identity word of config dword 0; values are arbitrary
`define PNA_VENDOR_ID 16'h1D0C
`define PNA_DEVICE_ID 16'h00A5

// Clocks without a claim before a master abort
`define PNA_MABORT_CYCLES 3'h5

// Data buffer shape: byte enables on top of the data word
`define PNA_FIFO_WIDTH 36
`define PNA_FIFO_DEPTH 8

`endif

/* pna_pkg.sv */
`default_nettype none
`include "pna_cfg.svh"

package pna_pkg;

	// Bus pins as sampled at the rising clock edge
	typedef struct packed {
		logic [31:0] ad;
		logic [3:0] cbe_n;
		logic par;
		logic frame_n;
		logic irdy_n;
		logic trdy_n;
		logic stop_n;
		logic devsel_n;
		logic idsel;
		logic gnt_n;
	} pna_bus_in_s;

	// Pin drive values with their output enables
	typedef struct packed {
		logic [31:0] ad;
		logic ad_oe;
		logic [3:0] cbe_n;
		logic cbe_oe;
		logic par;
		logic par_oe;
		logic frame_n;
		logic frame_oe;
		logic irdy_n;
		logic irdy_oe;
		logic trdy_n;
		logic trdy_oe;
		logic stop_n;
		logic stop_oe;
		logic devsel_n;
		logic devsel_oe;
		logic perr_n;
		logic perr_oe;
		logic serr_n;
		logic serr_oe;
		logic inta_n;
		logic inta_oe;
		logic req_n;
		logic req_oe;
	} pna_bus_out_s;

	// Single-word memory write asked of the master
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0] be;
	} pna_mst_req_s;

	// Outcome of a master request
	typedef struct packed {
		logic accepted;
		logic ok;
		logic aborted;
	} pna_mst_rsp_s;

	typedef enum logic [3:0] {
		T_IDLE = 4'h1,
		T_WAIT = 4'h2,
		T_DATA = 4'h4,
		T_TURN = 4'h8
	} pna_tgt_e;

	typedef enum logic [4:0] {
		M_IDLE = 5'h01,
		M_REQ = 5'h02,
		M_ADDR = 5'h04,
		M_DATA = 5'h08,
		M_TURN = 5'h10
	} pna_mst_e;

endpackage : pna_pkg

`default_nettype wire

/* pna_agent.sv */
`default_nettype none
`include "pna_cfg.svh"

// Synchronous FIFO with valid/ready on both sides
module pna_fifo #(
	parameter int WIDTH = `PNA_FIFO_WIDTH,
	parameter int DEPTH = `PNA_FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] free
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [CW-1:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != CW'(DEPTH));
	assign out_valid = (count_q != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_ptr_q];
	assign free = CW'(DEPTH) - count_q;

	// Storage array, written only on an accepted push
	always_ff @(posedge core_clk)
	begin
		if (push)
		begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	// Pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop)
			begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
			end
			if (push && !pop)
			begin
				count_q <= count_q + 1'b1;
			end
			else if (pop && !push)
			begin
				count_q <= count_q - 1'b1;
			end
		end
	end

endmodule : pna_fifo

module pna_agent (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire pna_pkg::pna_bus_in_s bus_sample,
	output pna_pkg::pna_bus_out_s bus_drive,
	input wire pna_pkg::pna_mst_req_s mst_cmd,
	output pna_pkg::pna_mst_rsp_s mst_done,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [`PNA_FIFO_WIDTH-1:0] wr_word,
	input wire logic [31:0] rd_data,
	output logic rd_taken,
	input wire logic irq_level
);
	localparam int FW = $clog2(`PNA_FIFO_DEPTH+1);

	// Decode of an address phase: bit 1 claims, bit 0 marks configuration
	function automatic logic [1:0] pna_decode(input logic [31:0] ad, input logic [3:0] cmd,
		input logic idsel);
		logic cfg;
		logic mem;
		cfg = idsel && (ad[1:0] == 2'h0)
			&& (cmd == `PNA_CMD_CFG_RD || cmd == `PNA_CMD_CFG_WR);
		mem = ((ad & `PNA_MEM_MASK) == `PNA_MEM_BASE)
			&& (cmd == `PNA_CMD_MEM_RD || cmd == `PNA_CMD_MEM_WR);
		return {cfg | mem, cfg};
	endfunction : pna_decode

	pna_pkg::pna_tgt_e t_state_q;
	pna_pkg::pna_mst_e m_state_q;
	logic frame_prev_q;
	logic t_read_q;
	logic t_cfg_q;
	logic [5:0] t_reg_q;
	logic devsel_q;
	logic trdy_q;
	logic stop_q;
	logic t_oe_q;
	logic [31:0] ad_q;
	logic ad_oe_q;
	logic [3:0] cbe_q;
	logic cbe_oe_q;
	logic par_q;
	logic par_oe_q;
	logic frame_q;
	logic irdy_q;
	logic m_oe_q;
	logic req_q;
	logic req_oe_q;
	logic [2:0] m_wait_q;
	pna_pkg::pna_mst_req_s m_cmd_q;
	pna_pkg::pna_mst_rsp_s done_q;
	logic apar_q;
	logic achk_q;
	logic serr_q;
	logic dpar_q;
	logic dchk_q;
	logic derr;
	logic perr_q;
	logic perr_oe_q;
	logic inta_q;
	logic rd_taken_q;
	logic [1:0] hit;
	logic addr_phase;
	logic t_done;
	logic t_end;
	logic t_write;
	logic push;
	logic accept;
	logic m_go;
	logic m_done;
	logic m_stop;
	logic m_abort;
	logic m_end;
	logic [31:0] t_word;
	logic [FW-1:0] fifo_free;
	logic fifo_in_ready;

	// Address phase is the edge on which FRAME is first seen low
	assign addr_phase = frame_prev_q & ~bus_sample.frame_n;
	assign hit = pna_decode(bus_sample.ad, bus_sample.cbe_n, bus_sample.idsel);

	// Target handshake terms, all on the pins at this edge
	assign t_done = (t_state_q == pna_pkg::T_DATA) & ~bus_sample.irdy_n & ~trdy_q;
	assign t_end = (t_state_q == pna_pkg::T_DATA) & bus_sample.frame_n & ~bus_sample.irdy_n
		& (~trdy_q | ~stop_q);
	assign t_write = ~t_read_q & ~t_cfg_q;
	assign push = t_done & t_write;

	// Conservative space test: a pop this cycle is not counted on
	assign accept = ~t_write | (fifo_free > FW'(1)) | ((fifo_free == FW'(1)) & ~push);
	assign t_word = t_cfg_q ? ((t_reg_q == 6'h00) ? {`PNA_DEVICE_ID, `PNA_VENDOR_ID} : 32'h0)
		: rd_data;

	// Master terms; the bus is taken only when idle and granted
	assign m_go = (m_state_q == pna_pkg::M_REQ) & ~bus_sample.gnt_n & bus_sample.frame_n
		& bus_sample.irdy_n & (t_state_q == pna_pkg::T_IDLE);
	assign m_done = ~irdy_q & ~bus_sample.trdy_n;
	assign m_stop = ~bus_sample.stop_n;
	assign m_abort = bus_sample.devsel_n & (m_wait_q == `PNA_MABORT_CYCLES - 3'h1);
	assign m_end = (m_state_q == pna_pkg::M_DATA) & (m_done | m_stop | m_abort);

	// Write data from the bus queues here; the user side can stall it
	pna_fifo #(
		.WIDTH(`PNA_FIFO_WIDTH),
		.DEPTH(`PNA_FIFO_DEPTH)
	) u_wr_fifo (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data({~bus_sample.cbe_n, bus_sample.ad}),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(wr_word),
		.free(fifo_free)
	);

	// FRAME history for address phase detection
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			frame_prev_q <= 1'b1;
		end
		else
		begin
			frame_prev_q <= bus_sample.frame_n;
		end
	end

	// Target sequencer; claims two clocks after the address (medium decode)
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			t_state_q <= pna_pkg::T_IDLE;
			t_read_q <= 1'b0;
			t_cfg_q <= 1'b0;
			t_reg_q <= 6'h00;
		end
		else
		begin
			case (t_state_q)
				pna_pkg::T_IDLE:
				begin
					if (addr_phase && hit[1] && m_state_q != pna_pkg::M_ADDR)
					begin
						t_state_q <= pna_pkg::T_WAIT;
						t_cfg_q <= hit[0];
						t_read_q <= ~bus_sample.cbe_n[0];
						t_reg_q <= bus_sample.ad[7:2];
					end
				end
				pna_pkg::T_WAIT:
				begin
					t_state_q <= pna_pkg::T_DATA;
				end
				pna_pkg::T_DATA:
				begin
					if (t_end)
					begin
						t_state_q <= pna_pkg::T_TURN;
					end
				end
				pna_pkg::T_TURN:
				begin
					t_state_q <= pna_pkg::T_IDLE;
				end
				default:
				begin
					t_state_q <= pna_pkg::T_IDLE;
				end
			endcase
		end
	end

	// Target control lines; a full buffer turns TRDY into a STOP disconnect
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			devsel_q <= 1'b1;
			trdy_q <= 1'b1;
			stop_q <= 1'b1;
			t_oe_q <= 1'b0;
		end
		else if (t_state_q == pna_pkg::T_WAIT)
		begin
			devsel_q <= 1'b0;
			trdy_q <= ~accept;
			stop_q <= accept;
			t_oe_q <= 1'b1;
		end
		else if (t_end)
		begin
			devsel_q <= 1'b1;
			trdy_q <= 1'b1;
			stop_q <= 1'b1;
		end
		else if (t_state_q == pna_pkg::T_DATA && stop_q && !accept)
		begin
			trdy_q <= 1'b1;
			stop_q <= 1'b0;
		end
		else if (t_state_q == pna_pkg::T_TURN)
		begin
			t_oe_q <= 1'b0;
		end
	end

	// Master sequencer: one memory write per granted tenure
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			m_state_q <= pna_pkg::M_IDLE;
			m_wait_q <= 3'h0;
			m_cmd_q <= '0;
		end
		else
		begin
			case (m_state_q)
				pna_pkg::M_IDLE:
				begin
					if (mst_cmd.valid && t_state_q == pna_pkg::T_IDLE)
					begin
						m_state_q <= pna_pkg::M_REQ;
					end
				end
				pna_pkg::M_REQ:
				begin
					if (m_go)
					begin
						m_state_q <= pna_pkg::M_ADDR;
						m_cmd_q <= mst_cmd;
					end
				end
				pna_pkg::M_ADDR:
				begin
					m_state_q <= pna_pkg::M_DATA;
					m_wait_q <= 3'h0;
				end
				pna_pkg::M_DATA:
				begin
					if (m_end)
					begin
						m_state_q <= pna_pkg::M_TURN;
					end
					else if (bus_sample.devsel_n)
					begin
						m_wait_q <= m_wait_q + 3'h1;
					end
				end
				pna_pkg::M_TURN:
				begin
					m_state_q <= pna_pkg::M_IDLE;
				end
				default:
				begin
					m_state_q <= pna_pkg::M_IDLE;
				end
			endcase
		end
	end

	// FRAME, IRDY and REQ; single phase, so FRAME rises as IRDY falls
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			frame_q <= 1'b1;
			irdy_q <= 1'b1;
			m_oe_q <= 1'b0;
			req_q <= 1'b1;
			req_oe_q <= 1'b0;
		end
		else
		begin
			req_oe_q <= 1'b1;
			req_q <= ~((m_state_q == pna_pkg::M_IDLE && mst_cmd.valid
				&& t_state_q == pna_pkg::T_IDLE) || (m_state_q == pna_pkg::M_REQ && !m_go));
			if (m_go)
			begin
				frame_q <= 1'b0;
				m_oe_q <= 1'b1;
			end
			else if (m_state_q == pna_pkg::M_ADDR)
			begin
				frame_q <= 1'b1;
				irdy_q <= 1'b0;
			end
			else if (m_end)
			begin
				irdy_q <= 1'b1;
			end
			else if (m_state_q == pna_pkg::M_TURN)
			begin
				m_oe_q <= 1'b0;
			end
		end
	end

	// Master result pulse; a retry re-arbitrates without reporting
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			done_q <= '0;
		end
		else
		begin
			done_q.ok <= m_end & m_done;
			done_q.aborted <= m_end & ~m_done & (m_abort | bus_sample.devsel_n);
			done_q.accepted <= m_end & (m_done | m_abort | bus_sample.devsel_n);
		end
	end

	// Shared AD and command lanes, driven by whichever role owns them
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ad_q <= 32'h0000_0000;
			ad_oe_q <= 1'b0;
			cbe_q <= 4'hF;
			cbe_oe_q <= 1'b0;
		end
		else if (m_go)
		begin
			ad_q <= mst_cmd.addr;
			cbe_q <= `PNA_CMD_MEM_WR;
			ad_oe_q <= 1'b1;
			cbe_oe_q <= 1'b1;
		end
		else if (m_state_q == pna_pkg::M_ADDR)
		begin
			ad_q <= m_cmd_q.data;
			cbe_q <= ~m_cmd_q.be;
		end
		else if (m_end)
		begin
			ad_oe_q <= 1'b0;
			cbe_oe_q <= 1'b0;
		end
		else if (t_state_q == pna_pkg::T_WAIT && t_read_q)
		begin
			ad_q <= t_word;
			ad_oe_q <= 1'b1;
		end
		else if (t_state_q == pna_pkg::T_DATA && t_read_q)
		begin
			if (t_end)
			begin
				ad_oe_q <= 1'b0;
			end
			else if (t_done)
			begin
				ad_q <= t_word;
			end
		end
	end

	// Parity trails the lanes it covers by one clock, so it holds past completion
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			par_q <= 1'b0;
			par_oe_q <= 1'b0;
		end
		else
		begin
			par_q <= ^{ad_q, bus_sample.cbe_n};
			par_oe_q <= ad_oe_q;
		end
	end

	// Address parity: check the clock after the address, SERR for one clock
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			apar_q <= 1'b0;
			achk_q <= 1'b0;
			serr_q <= 1'b0;
		end
		else
		begin
			apar_q <= ^{bus_sample.ad, bus_sample.cbe_n};
			achk_q <= addr_phase;
			serr_q <= achk_q & (apar_q != bus_sample.par);
		end
	end

	// Data parity on claimed writes: lines held at completion, parity one clock on
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dpar_q <= 1'b0;
			dchk_q <= 1'b0;
		end
		else
		begin
			dpar_q <= ^{bus_sample.ad, bus_sample.cbe_n};
			dchk_q <= t_done & ~t_read_q & ~devsel_q;
		end
	end

	// Compared on the edge after completion; a further flop would make PERR a clock late
	assign derr = dchk_q & (dpar_q != bus_sample.par);

	// PERR low per erroneous phase, then high one clock before release
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			perr_q <= 1'b1;
			perr_oe_q <= 1'b0;
		end
		else if (derr)
		begin
			perr_q <= 1'b0;
			perr_oe_q <= 1'b1;
		end
		else if (!perr_q)
		begin
			perr_q <= 1'b1;
		end
		else
		begin
			perr_oe_q <= 1'b0;
		end
	end

	// Interrupt level and read-advance pulse, both from flops
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			inta_q <= 1'b0;
			rd_taken_q <= 1'b0;
		end
		else
		begin
			inta_q <= irq_level;
			rd_taken_q <= t_done & t_read_q & ~t_cfg_q;
		end
	end

	// Pin drive; open-drain lines carry a constant low and only steer enable
	assign bus_drive.ad = ad_q;
	assign bus_drive.ad_oe = ad_oe_q;
	assign bus_drive.cbe_n = cbe_q;
	assign bus_drive.cbe_oe = cbe_oe_q;
	assign bus_drive.par = par_q;
	assign bus_drive.par_oe = par_oe_q;
	assign bus_drive.frame_n = frame_q;
	assign bus_drive.frame_oe = m_oe_q;
	assign bus_drive.irdy_n = irdy_q;
	assign bus_drive.irdy_oe = m_oe_q;
	assign bus_drive.trdy_n = trdy_q;
	assign bus_drive.trdy_oe = t_oe_q;
	assign bus_drive.stop_n = stop_q;
	assign bus_drive.stop_oe = t_oe_q;
	assign bus_drive.devsel_n = devsel_q;
	assign bus_drive.devsel_oe = t_oe_q;
	assign bus_drive.perr_n = perr_q;
	assign bus_drive.perr_oe = perr_oe_q;
	assign bus_drive.serr_n = 1'b0;
	assign bus_drive.serr_oe = serr_q;
	assign bus_drive.inta_n = 1'b0;
	assign bus_drive.inta_oe = inta_q;
	assign bus_drive.req_n = req_q;
	assign bus_drive.req_oe = req_oe_q;
	assign mst_done = done_q;
	assign rd_taken = rd_taken_q;

endmodule : pna_agent

`default_nettype wire

/* pna_chk_assertions.sv */
`default_nettype none
`include "pna_cfg.svh"

module pna_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire pna_pkg::pna_bus_in_s bus_sample,
	input wire pna_pkg::pna_bus_out_s bus_drive,
	input wire logic irq_level
);
	timeunit 1ns;
	timeprecision 1ps;

	logic done_q;
	logic [35:0] word_q;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	// Claimed write phase finished on this edge; the receiver checks parity an edge later
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			done_q <= 1'b0;
		else
			done_q <= bus_drive.devsel_oe && !bus_drive.devsel_n && !bus_drive.ad_oe
				&& !bus_sample.irdy_n && !bus_sample.trdy_n;
	end

	// Lines of the last edge; done_q gates its use, so no reset is needed
	always_ff @(posedge core_clk)
	begin
		word_q <= {bus_sample.ad, bus_sample.cbe_n};
	end

	sequence hit_s;
		$fell(bus_sample.frame_n) && !bus_drive.frame_oe
			&& ((bus_sample.cbe_n[3:1] == 3'h3
			&& (bus_sample.ad & `PNA_MEM_MASK) == `PNA_MEM_BASE)
			|| (bus_sample.cbe_n[3:1] == 3'h5 && bus_sample.idsel && bus_sample.ad[1:0] == 2'h0));
	endsequence

	sequence apar_bad_s;
		bus_sample.par != ^{$past(bus_sample.ad), $past(bus_sample.cbe_n)};
	endsequence

	trdy_release_a: assert property ($fell(bus_drive.trdy_oe) |-> $past(bus_drive.trdy_n))
		else $error("ready line floated while low");
	devsel_release_a: assert property ($fell(bus_drive.devsel_oe) |-> $past(bus_drive.devsel_n))
		else $error("select line floated while low");
	par_check_a: assert property (bus_drive.ad_oe |=> bus_drive.par_oe
		&& bus_drive.par == ^{$past(bus_sample.ad), $past(bus_sample.cbe_n)})
		else $error("parity wrong or late");
	devsel_claim_a: assert property (hit_s |-> ##[1:3] bus_drive.devsel_oe && !bus_drive.devsel_n)
		else $error("own address not claimed");
	apar_serr_a: assert property (hit_s ##1 apar_bad_s |=> bus_drive.serr_oe)
		else $error("address parity error not reported");
	serr_pulse_a: assert property ($rose(bus_drive.serr_oe) |=> !bus_drive.serr_oe)
		else $error("system error longer than one clock");
	od_low_a: assert property (bus_drive.serr_oe || bus_drive.inta_oe
		|-> !bus_drive.serr_n && !bus_drive.inta_n)
		else $error("open drain line driven high");
	inta_level_a: assert property (1'b1 |=> bus_drive.inta_oe == $past(irq_level))
		else $error("interrupt pin does not follow the level");
	perr_flag_a: assert property (done_q && (bus_sample.par != ^word_q)
		|=> bus_drive.perr_oe && !bus_drive.perr_n)
		else $error("data parity error not reported");
	perr_claim_a: assert property ($fell(bus_drive.perr_n) && bus_drive.perr_oe |-> $past(done_q))
		else $error("parity error without a claimed phase");
	grant_first_a: assert property ($rose(bus_drive.frame_oe) |-> !bus_drive.frame_n
		&& !$past(bus_sample.gnt_n) && $past(bus_sample.irdy_n))
		else $error("frame started without grant on an idle bus");
	frame_last_a: assert property (bus_drive.frame_oe && !bus_drive.frame_n
		|=> bus_drive.frame_n && !bus_drive.irdy_n)
		else $error("frame not dropped in the single data phase");
endmodule : pna_chk

bind pna_agent pna_chk chk_u (.core_clk(core_clk), .reset_n(reset_n), .bus_sample(bus_sample),
	.bus_drive(bus_drive), .irq_level(irq_level));

`default_nettype wire

/* pna_host.sv */
`default_nettype none

// Host bridge, arbiter and memory target facing the agent; resolves every shared line the agent samples
module pna_host (
	input wire logic core_clk,
	input wire pna_pkg::pna_bus_out_s dev,
	output pna_pkg::pna_bus_in_s smp
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [31:0] m_ad = 32'h0, junk = 32'h0, cap_addr, cap_data;
	logic [3:0] m_cbe = 4'hF, cap_be;
	logic m_frame = 1'b1, m_irdy = 1'b1, m_oe = 1'b0, m_adoe = 1'b0, m_ctl = 1'b0;
	logic m_par = 1'b0, m_par_oe = 1'b0, par_bad = 1'b0, idsel = 1'b0, gnt_n = 1'b1;
	logic t_oe = 1'b0, t_dev = 1'b1, t_trdy = 1'b1, claim = 1'b1;

	// Floating data lines show changing junk; control lines have pull-ups
	always_comb
	begin
		smp.ad = dev.ad_oe ? dev.ad : (m_adoe ? m_ad : junk);
		smp.cbe_n = dev.cbe_oe ? dev.cbe_n : (m_oe ? m_cbe : junk[3:0]);
		smp.par = dev.par_oe ? dev.par : (m_par_oe ? m_par : junk[4]);
		smp.frame_n = dev.frame_oe ? dev.frame_n : (m_ctl ? m_frame : 1'b1);
		smp.irdy_n = dev.irdy_oe ? dev.irdy_n : (m_ctl ? m_irdy : 1'b1);
		smp.trdy_n = dev.trdy_oe ? dev.trdy_n : (t_oe ? t_trdy : 1'b1);
		smp.devsel_n = dev.devsel_oe ? dev.devsel_n : (t_oe ? t_dev : 1'b1);
		smp.stop_n = dev.stop_oe ? dev.stop_n : 1'b1;
		smp.idsel = idsel;
		smp.gnt_n = gnt_n;
	end

	// Parity lags its lines by a clock and so holds one clock past the phase
	always_ff @(posedge core_clk)
	begin
		m_par <= ^{m_ad, m_cbe} ^ par_bad;
		m_par_oe <= m_adoe;
		if (dev.ad_oe || m_adoe)
		begin
			junk <= ~smp.ad;
		end
		else
		begin
			junk <= ~junk;
		end
		gnt_n <= !(dev.req_oe && !dev.req_n && !m_ctl);
	end

	// Fast-decode target for the agent's writes; never retries
	always_ff @(posedge core_clk)
	begin
		if (dev.frame_oe && !dev.frame_n && claim)
		begin
			t_oe <= 1'b1;
			t_dev <= 1'b0;
			t_trdy <= 1'b0;
			cap_addr <= smp.ad;
		end
		else if (t_oe && !t_trdy && !smp.irdy_n)
		begin
			t_dev <= 1'b1;
			t_trdy <= 1'b1;
			cap_data <= smp.ad;
			cap_be <= ~smp.cbe_n;
		end
		else if (t_oe && t_trdy)
		begin
			t_oe <= 1'b0;
		end
	end

	// Single-phase initiator cycle; how is 0 unclaimed, 1 done, 2 stopped
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] wdata,
		input logic [3:0] be, input logic sel, input logic [1:0] bad,
		output logic [31:0] rdata, output logic [1:0] how);
		@(posedge core_clk);
		m_frame <= 1'b0;
		m_ctl <= 1'b1;
		m_oe <= 1'b1;
		m_adoe <= 1'b1;
		m_ad <= addr;
		m_cbe <= cmd;
		idsel <= sel;
		par_bad <= bad[0];
		@(posedge core_clk);
		m_frame <= 1'b1;
		m_irdy <= 1'b0;
		m_cbe <= ~be;
		m_adoe <= cmd[0];
		m_ad <= wdata;
		idsel <= 1'b0;
		par_bad <= bad[1];
		how = 2'h0;
		rdata = 32'h0;
		for (int i = 0; i < 8 && how == 2'h0; i++)
		begin
			@(negedge core_clk);
			rdata = smp.ad;
			how = !smp.trdy_n ? 2'h1 : (!smp.stop_n ? 2'h2 : 2'h0);
			@(posedge core_clk);
		end
		m_irdy <= 1'b1;
		m_oe <= 1'b0;
		m_adoe <= 1'b0;
		@(posedge core_clk);
		m_ctl <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : xfer
endmodule : pna_host

`default_nettype wire

/* tb.sv */
`default_nettype none
`include "pna_cfg.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	pna_pkg::pna_bus_in_s bus_sample;
	pna_pkg::pna_bus_out_s bus_drive;
	pna_pkg::pna_mst_req_s mst_cmd = '0;
	pna_pkg::pna_mst_rsp_s mst_done;
	logic wr_valid, rd_taken, wr_ready = 1'b0, irq_level = 1'b0;
	logic [35:0] wr_word;
	logic [31:0] rd_data = 32'h0, rdata, wdata, maddr;
	logic [11:0] oe_all;
	logic [3:0] be;
	logic [1:0] how, res;
	logic [35:0] exp_q[$];
	int errors = 0, samples_checked = 0, perr_cnt = 0, serr_cnt = 0, rd_cnt = 0;

	pna_agent dut_u (.core_clk(core_clk), .reset_n(reset_n), .bus_sample(bus_sample),
		.bus_drive(bus_drive), .mst_cmd(mst_cmd), .mst_done(mst_done), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_word(wr_word), .rd_data(rd_data), .rd_taken(rd_taken),
		.irq_level(irq_level));
	pna_host host_u (.core_clk(core_clk), .dev(bus_drive), .smp(bus_sample));

	assign oe_all = {bus_drive.ad_oe, bus_drive.cbe_oe, bus_drive.par_oe, bus_drive.frame_oe,
		bus_drive.irdy_oe, bus_drive.trdy_oe, bus_drive.stop_oe, bus_drive.devsel_oe,
		bus_drive.perr_oe, bus_drive.serr_oe, bus_drive.inta_oe, bus_drive.req_oe};

	initial
	begin
		forever #5 core_clk = ~core_clk;
	end

	// Error pins and read pulses are counted mid-cycle, where they are settled
	always @(negedge core_clk)
	begin
		perr_cnt += int'(bus_drive.perr_oe && !bus_drive.perr_n);
		serr_cnt += int'(bus_drive.serr_oe && !bus_drive.serr_n);
		rd_cnt += int'(rd_taken);
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_of_test;
		$display("compares %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	task automatic do_reset;
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		chk(oe_all, 12'h0);
		reset_n <= 1'b1;
	endtask : do_reset

	// A hang cannot outlast twenty thousand clocks
	initial
	begin
		#200000;
		errors++;
		end_of_test();
	end

	initial
	begin
		void'($urandom(32'h8D9738BC));
		do_reset();
		host_u.xfer(`PNA_CMD_CFG_RD, 32'h0, 32'h0, 4'hF, 1'b1, 2'h0, rdata, how);
		chk({how, rdata}, {2'h1, `PNA_DEVICE_ID, `PNA_VENDOR_ID});
		host_u.xfer(`PNA_CMD_CFG_RD, 32'h0, 32'h0, 4'hF, 1'b0, 2'h0, rdata, how);
		chk(how, 2'h0);
		host_u.xfer(`PNA_CMD_CFG_WR, 32'h4, $urandom, 4'hF, 1'b1, 2'h0, rdata, how);
		chk({how, wr_valid}, 3'h2);
		$display("config test done");
		// Overfill the buffer by one with nobody popping: the extra write must be stopped
		for (int i = 0; i <= `PNA_FIFO_DEPTH; i++)
		begin
			wdata = $urandom;
			be = (i == 0) ? 4'h0 : 4'($urandom);
			maddr = `PNA_MEM_BASE | (i == 1 ? 32'hFFC : ($urandom & 32'hFFC));
			host_u.xfer(`PNA_CMD_MEM_WR, maddr, wdata, be, 1'b0, 2'h0, rdata, how);
			chk(how, (i < `PNA_FIFO_DEPTH) ? 2'h1 : 2'h2);
			if (how == 2'h1)
				exp_q.push_back({be, wdata});
		end
		// Drain while the consumer stalls at random
		for (int i = 0; i < 40; i++)
		begin
			@(posedge core_clk);
			wr_ready <= 1'($urandom);
			@(negedge core_clk);
			if (wr_valid && wr_ready && exp_q.size() > 0)
				chk(wr_word, exp_q.pop_front());
		end
		@(posedge core_clk);
		wr_ready <= 1'b0;
		@(negedge core_clk);
		chk({exp_q.size() == 0, wr_valid}, 2'h2);
		@(posedge core_clk);
		wr_ready <= 1'b1;
		$display("buffer test done");
		host_u.xfer(`PNA_CMD_MEM_WR, `PNA_MEM_BASE, $urandom, 4'hF, 1'b0, 2'h2, rdata, how);
		chk({how, 4'(perr_cnt), 4'(serr_cnt)}, {2'h1, 4'h1, 4'h0});
		host_u.xfer(`PNA_CMD_MEM_WR, `PNA_MEM_BASE, $urandom, 4'hF, 1'b0, 2'h1, rdata, how);
		chk({4'(perr_cnt), 4'(serr_cnt)}, {4'h1, 4'h1});
		$display("parity test done");
		for (int i = 0; i < 3; i++)
		begin
			@(posedge core_clk);
			rd_data <= $urandom;
			host_u.xfer(`PNA_CMD_MEM_RD, `PNA_MEM_BASE | 32'(i * 4), 32'h0, 4'($urandom), 1'b0,
				2'h0, rdata, how);
			chk({how, rdata}, {2'h1, rd_data});
		end
		chk(rd_cnt, 3);
		$display("read test done");
		// Own writes: first claimed by the host, then left unclaimed
		for (int i = 0; i < 2; i++)
		begin
			host_u.claim <= (i == 0);
			wdata = $urandom;
			be = 4'($urandom);
			maddr = $urandom & 32'h7FFF_FFFC;
			res = 2'h0;
			@(posedge core_clk);
			mst_cmd <= {1'b1, maddr, wdata, be};
			for (int k = 0; k < 60 && res == 2'h0; k++)
			begin
				@(negedge core_clk);
				res = {mst_done.aborted, mst_done.ok};
				@(posedge core_clk);
				if (mst_done.accepted || res != 2'h0)
					mst_cmd.valid <= 1'b0;
			end
			chk(res, (i == 0) ? 2'h1 : 2'h2);
			if (i == 0)
				chk({host_u.cap_addr, host_u.cap_data, host_u.cap_be}, {maddr, wdata, be});
			repeat (4) @(posedge core_clk);
		end
		$display("master test done");
		irq_level <= 1'b1;
		repeat (2) @(posedge core_clk);
		irq_level <= 1'b0;
		@(negedge core_clk);
		chk({bus_drive.inta_oe, bus_drive.inta_n}, 2'h2);
		repeat (2) @(negedge core_clk);
		chk(bus_drive.inta_oe, 1'b0);
		$display("interrupt test done");
		do_reset();
		host_u.xfer(`PNA_CMD_CFG_RD, 32'h0, 32'h0, 4'hF, 1'b1, 2'h0, rdata, how);
		chk(how, 2'h1);
		$display("reset test done");
		end_of_test();
	end
endmodule : tb

`default_nettype wire
